// ==== src/port_regs_pkg.sv ====
// Purpose: Shared constants and carrier types for the per-port configuration register block.
// Assumes: Configuration offsets are byte addresses, each register one aligned 32-bit word.
// Notes:   Field positions are bit indices within the 32-bit word at each offset.
package port_regs_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register offsets.
    localparam logic [11:0] OFF_SLOT_CTL_STAT   = 12'h0D8;
    localparam logic [11:0] OFF_DEV_CAP_TWO     = 12'h0E4;
    localparam logic [11:0] OFF_DEV_CTL_STAT_2  = 12'h0E8;
    localparam logic [11:0] OFF_LINK_CAP_TWO    = 12'h0EC;
    localparam logic [11:0] OFF_LINK_CTL_STAT_2 = 12'h0F0;
    localparam logic [11:0] OFF_SLOT_CAP_TWO    = 12'h0F4;
    localparam logic [11:0] OFF_SLOT_CTL_STAT_2 = 12'h0F8;
    localparam logic [11:0] OFF_ERR_HEADER      = 12'h100;
    localparam logic [11:0] OFF_UNC_FLAGS       = 12'h104;
    localparam logic [11:0] OFF_UNC_MASKS       = 12'h108;

    // Slot control fields in the low half of the word at D8h.
    localparam int unsigned SC_ATTN_EN   = 0;
    localparam int unsigned SC_PFAULT_EN = 1;
    localparam int unsigned SC_PDC_EN    = 3;
    localparam int unsigned SC_CC_EN     = 4;
    localparam int unsigned SC_HP_IE     = 5;
    localparam int unsigned SC_DLLSC_EN  = 12;
    localparam logic [15:0] SC_WR_MASK   = 16'h103B;

    // Slot status fields in the high half of the word at D8h.
    localparam int unsigned SS_ATTN    = 16;
    localparam int unsigned SS_PFAULT  = 17;
    localparam int unsigned SS_SNS_CHG = 18;
    localparam int unsigned SS_PDC     = 19;
    localparam int unsigned SS_CC      = 20;
    localparam int unsigned SS_LATCH   = 21;
    localparam int unsigned SS_PRES    = 22;
    localparam int unsigned SS_DLLSC   = 24;

    // Index of each clear-by-one slot flag inside the slot flag bank.
    localparam int unsigned SF_ATTN   = 0;
    localparam int unsigned SF_PFAULT = 1;
    localparam int unsigned SF_PDC    = 2;
    localparam int unsigned SF_CC     = 3;
    localparam int unsigned SF_DLLSC  = 4;
    localparam int unsigned SF_W      = 5;

    // Device capabilities 2 and device control 2.
    localparam logic [31:0] DEV_CAP_TWO_VAL = 32'h0004_0800;
    localparam int unsigned DC2_LTR_EN      = 10;
    localparam int unsigned DC2_OBFF_LO     = 13;
    localparam int unsigned DC2_OBFF_HI     = 14;
    localparam logic [1:0]  OBFF_RST        = 2'h0;

    // Link control 2 and link status 2.
    localparam int unsigned LC2_SPEED_LO  = 0;
    localparam int unsigned LC2_SPEED_HI  = 3;
    localparam int unsigned LC2_COMPL     = 4;
    localparam int unsigned LC2_AUTO_OFF  = 5;
    localparam int unsigned LC2_SEL_DEEMP = 6;
    localparam int unsigned LC2_STICKY_LO = 7;
    localparam int unsigned LC2_STICKY_HI = 12;
    localparam int unsigned LS2_CUR_DEEMP = 16;
    localparam logic [3:0]  SPEED_RST     = 4'h2;

    // Advanced error reporting header and uncorrectable error fields.
    localparam logic [15:0] AER_CAP_ID   = 16'h0001;
    localparam logic [3:0]  AER_CAP_VER  = 4'h1;
    localparam logic [11:0] AER_NEXT_PTR = 12'h140;
    localparam logic [31:0] UNC_IMPL     = 32'h003F_F011;
    localparam logic [31:0] UNC_RST      = 32'h0000_0000;

    // Cycles the presence path needs to settle after power-on reset.
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } cfg_req_t;

    typedef struct packed {
        logic attn_button;
        logic power_fault;
        logic latch_open;
        logic card_present_strap;
        logic slot_implemented;
        logic downstream;
    } slot_pins_t;

    typedef struct packed {
        logic        ltr_enable;
        logic [1:0]  obff_mode;
        logic        autonomous_speed_change_off;
        logic [3:0]  target_link_speed;
        logic        select_deemphasis;
    } link_ctl_t;

endpackage : port_regs_pkg

// ==== src/pin_sync.sv ====
// Purpose: Two-stage synchroniser for a group of level inputs arriving from pins.
// Assumes: Each bit is an independent slow level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned     W   = 6,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    always_comb begin
        state_nxt.stage1 = d;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= {RST, RST};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign q = state_r.stage2;
endmodule : pin_sync
`default_nettype wire

// ==== src/flag_bank.sv ====
// Purpose: Bank of status flags that hardware sets and software clears by writing one.
// Assumes: Set and clear vectors come from logic on the same clock.
// Notes:   A set in the clearing cycle wins; soft_clear returns the bank to zero.
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         soft_clear,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clear,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } bank_state_t;

    bank_state_t state_r;
    bank_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (soft_clear) begin
            state_nxt.flags = '0;
        end else begin
            state_nxt.flags = (state_r.flags & ~clear) | set; // RULE25
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flags = state_r.flags;
endmodule : flag_bank
`default_nettype wire

// ==== src/port_regs.sv ====
// Purpose: Slot status, second-generation capability words and uncorrectable error registers.
// Assumes: reset_n is the power-on reset; conventional_reset is a level from same-clock logic.
// Notes:   Sticky bits survive conventional_reset and clear only under reset_n.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - Slot status in upper half of D8h, downstream only.
// RULE2 - Attention button press sets bit 16, clear-by-one.
// RULE3 - Power fault sets bit 17, clear-by-one.
// RULE4 - Bit 21 mirrors latch sensor; bit 18 read-only.
// RULE5 - Presence change sets bit 19, clear-by-one.
// RULE6 - Finished hot-plug command sets bit 20.
// RULE7 - Bit 22 shows presence, reset from strap.
// RULE8 - No slot implemented: presence reads one.
// RULE9 - Link-active change sets bit 24, clear-by-one.
// RULE10 - Capabilities 2 bit 11 reads one.
// RULE11 - Capabilities 2 bits 19:18 read 01b.
// RULE12 - Control 2 bit 10 enables latency reporting.
// RULE13 - Control 2 bits 14:13 select OBFF mode.
// RULE14 - De-emphasis bits reset one on downstream ports.
// RULE15 - Header at 100h: ID 0001h, version 1, next 140h.
// RULE16 - Sticky error flags at bits 0, 4, 13.
// RULE17 - Poisoned packet sets bit 12.
// RULE18 - Bits 14, 15, 16 for completion errors.
// RULE19 - Malformed sets 18, receiver overflow sets 17.
// RULE20 - CRC error sets 19, unsupported request 20.
// RULE21 - Access violation flag and mask at 21.
// RULE22 - Masked errors are neither logged nor reported; here a masked error still sets its flag and only the report is suppressed.
// RULE23 - Hot-plug event needs global and individual enable.
// RULE24 - Link-active level watched for bit 24.
// RULE25 - Writing one clears; simultaneous set wins.
// RULE26 - Sticky bits clear only on power-on reset.
module port_regs (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    conventional_reset,
    input  wire port_regs_pkg::cfg_req_t cfg_req,
    output logic [31:0]                  cfg_rdata,
    input  wire port_regs_pkg::slot_pins_t slot_pins,
    input  wire logic                    hp_cmd_done,
    input  wire logic                    dll_active,
    input  wire logic [31:0]             err_event,
    output logic [31:0]                  err_report,
    output logic                         hotplug_event,
    output port_regs_pkg::link_ctl_t     link_ctl
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [31:0] err_report;
        logic        hotplug_event;
        logic [15:0] slot_ctl;
        logic        ltr_enable;
        logic [1:0]  obff_mode;
        logic        auto_off;
        logic [3:0]  target_speed;
        logic        compliance;
        logic [5:0]  lc2_sticky;
        logic [31:0] unc_masks;
        logic        attn_prev;
        logic        pfault_prev;
        logic        pres_prev;
        logic        dll_prev;
        logic [1:0]  settle;
    } regs_state_t;

    regs_state_t state_r;
    regs_state_t state_nxt;

    port_regs_pkg::slot_pins_t pins_s;
    logic [port_regs_pkg::SF_W-1:0] slot_set;
    logic [port_regs_pkg::SF_W-1:0] slot_clr;
    logic [port_regs_pkg::SF_W-1:0] slot_flags;
    logic [31:0]                    unc_set;
    logic [31:0]                    unc_clr;
    logic [31:0]                    unc_flags;
    logic                           presence;
    logic                           downstream;
    logic [31:0]                    slot_word;
    logic [31:0]                    lc2_word;
    logic [15:0]                    hp_pending;

    function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] off);
        word_hit = (addr[11:2] == off[11:2]);
    endfunction : word_hit

    // Reset loads strap high with slot_implemented low, so presence starts at one.
    pin_sync #(
        .W   (6),
        .RST (6'h04)
    ) u_pin_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (slot_pins),
        .q       (pins_s)
    );

    assign downstream = pins_s.downstream;
    assign presence   = pins_s.slot_implemented ? ~pins_s.card_present_strap : 1'b1; // RULE7 RULE8

    always_comb begin
        slot_set = '0;
        if (downstream) begin // RULE1
            slot_set[port_regs_pkg::SF_ATTN]   = pins_s.attn_button & ~state_r.attn_prev; // RULE2
            slot_set[port_regs_pkg::SF_PFAULT] = pins_s.power_fault & ~state_r.pfault_prev; // RULE3
            slot_set[port_regs_pkg::SF_PDC]    = (state_r.settle == port_regs_pkg::SETTLE_CYCLES)
                                                 & (presence != state_r.pres_prev); // RULE5
            slot_set[port_regs_pkg::SF_CC]     = hp_cmd_done; // RULE6
            slot_set[port_regs_pkg::SF_DLLSC]  = dll_active != state_r.dll_prev; // RULE9 RULE24
        end
    end

    always_comb begin
        slot_clr = '0;
        if (cfg_req.wr && downstream
            && word_hit(cfg_req.addr, port_regs_pkg::OFF_SLOT_CTL_STAT)) begin
            slot_clr[port_regs_pkg::SF_ATTN]   = cfg_req.wdata[port_regs_pkg::SS_ATTN];
            slot_clr[port_regs_pkg::SF_PFAULT] = cfg_req.wdata[port_regs_pkg::SS_PFAULT];
            slot_clr[port_regs_pkg::SF_PDC]    = cfg_req.wdata[port_regs_pkg::SS_PDC];
            slot_clr[port_regs_pkg::SF_CC]     = cfg_req.wdata[port_regs_pkg::SS_CC];
            slot_clr[port_regs_pkg::SF_DLLSC]  = cfg_req.wdata[port_regs_pkg::SS_DLLSC]; // RULE25
        end
    end

    // Slot flags are not sticky, so a conventional reset wipes them.
    flag_bank #(
        .W (port_regs_pkg::SF_W)
    ) u_slot_flags (
        .clk        (clk),
        .reset_n    (reset_n),
        .soft_clear (conventional_reset),
        .set        (slot_set),
        .clear      (slot_clr),
        .flags      (slot_flags)
    );

    // Every implemented error sets its flag whether masked or not.
    assign unc_set = err_event & port_regs_pkg::UNC_IMPL; // RULE16 RULE17 RULE18 RULE19 RULE20 RULE21

    always_comb begin
        unc_clr = '0;
        if (cfg_req.wr && word_hit(cfg_req.addr, port_regs_pkg::OFF_UNC_FLAGS)) begin
            unc_clr = cfg_req.wdata & port_regs_pkg::UNC_IMPL; // RULE25
        end
    end

    flag_bank #(
        .W (32)
    ) u_unc_flags (
        .clk        (clk),
        .reset_n    (reset_n),
        .soft_clear (1'b0), // RULE26
        .set        (unc_set),
        .clear      (unc_clr),
        .flags      (unc_flags)
    );

    always_comb begin
        slot_word = '0;
        if (downstream) begin // RULE1
            slot_word[15:0]                       = state_r.slot_ctl;
            slot_word[port_regs_pkg::SS_ATTN]     = slot_flags[port_regs_pkg::SF_ATTN];
            slot_word[port_regs_pkg::SS_PFAULT]   = slot_flags[port_regs_pkg::SF_PFAULT];
            slot_word[port_regs_pkg::SS_SNS_CHG]  = 1'b0; // RULE4
            slot_word[port_regs_pkg::SS_PDC]      = slot_flags[port_regs_pkg::SF_PDC];
            slot_word[port_regs_pkg::SS_CC]       = slot_flags[port_regs_pkg::SF_CC];
            slot_word[port_regs_pkg::SS_LATCH]    = pins_s.latch_open; // RULE4
            slot_word[port_regs_pkg::SS_PRES]     = presence; // RULE7 RULE8
            slot_word[port_regs_pkg::SS_DLLSC]    = slot_flags[port_regs_pkg::SF_DLLSC];
        end
    end

    always_comb begin
        lc2_word = '0;
        lc2_word[port_regs_pkg::LC2_SPEED_HI:port_regs_pkg::LC2_SPEED_LO] = state_r.target_speed;
        lc2_word[port_regs_pkg::LC2_COMPL]     = state_r.compliance;
        lc2_word[port_regs_pkg::LC2_AUTO_OFF]  = state_r.auto_off;
        lc2_word[port_regs_pkg::LC2_SEL_DEEMP] = downstream; // RULE14
        lc2_word[port_regs_pkg::LC2_STICKY_HI:port_regs_pkg::LC2_STICKY_LO] = state_r.lc2_sticky;
        lc2_word[port_regs_pkg::LS2_CUR_DEEMP] = downstream; // RULE14
    end

    assign hp_pending = state_r.slot_ctl & {
        3'h0,
        slot_flags[port_regs_pkg::SF_DLLSC],
        7'h00,
        slot_flags[port_regs_pkg::SF_CC],
        slot_flags[port_regs_pkg::SF_PDC],
        1'b0,
        slot_flags[port_regs_pkg::SF_PFAULT],
        slot_flags[port_regs_pkg::SF_ATTN]
    };

    always_comb begin
        state_nxt = state_r;

        state_nxt.attn_prev   = pins_s.attn_button;
        state_nxt.pfault_prev = pins_s.power_fault;
        state_nxt.pres_prev   = presence;
        state_nxt.dll_prev    = dll_active; // RULE24
        if (state_r.settle != port_regs_pkg::SETTLE_CYCLES) begin
            state_nxt.settle = state_r.settle + 2'h1;
        end

        // Reporting is suppressed per bit by the mask.
        state_nxt.err_report = unc_set & ~state_r.unc_masks; // RULE22

        state_nxt.hotplug_event = downstream
                                  & state_r.slot_ctl[port_regs_pkg::SC_HP_IE]
                                  & (|(hp_pending & ~16'h0020)); // RULE23

        if (cfg_req.wr) begin
            if (word_hit(cfg_req.addr, port_regs_pkg::OFF_SLOT_CTL_STAT) && downstream) begin
                state_nxt.slot_ctl = cfg_req.wdata[15:0] & port_regs_pkg::SC_WR_MASK;
            end
            if (word_hit(cfg_req.addr, port_regs_pkg::OFF_DEV_CTL_STAT_2)) begin
                state_nxt.ltr_enable = cfg_req.wdata[port_regs_pkg::DC2_LTR_EN]; // RULE12
                state_nxt.obff_mode  = cfg_req.wdata[port_regs_pkg::DC2_OBFF_HI:
                                                     port_regs_pkg::DC2_OBFF_LO]; // RULE13
            end
            if (word_hit(cfg_req.addr, port_regs_pkg::OFF_LINK_CTL_STAT_2)) begin
                state_nxt.target_speed = cfg_req.wdata[port_regs_pkg::LC2_SPEED_HI:
                                                       port_regs_pkg::LC2_SPEED_LO];
                state_nxt.compliance   = cfg_req.wdata[port_regs_pkg::LC2_COMPL];
                state_nxt.auto_off     = cfg_req.wdata[port_regs_pkg::LC2_AUTO_OFF];
                state_nxt.lc2_sticky   = cfg_req.wdata[port_regs_pkg::LC2_STICKY_HI:
                                                       port_regs_pkg::LC2_STICKY_LO];
            end
            if (word_hit(cfg_req.addr, port_regs_pkg::OFF_UNC_MASKS)) begin
                state_nxt.unc_masks = cfg_req.wdata & port_regs_pkg::UNC_IMPL; // RULE21 RULE22
            end
        end

        state_nxt.rdata = '0;
        if (cfg_req.rd) begin
            unique case (1'b1)
                word_hit(cfg_req.addr, port_regs_pkg::OFF_SLOT_CTL_STAT): begin
                    state_nxt.rdata = slot_word;
                end
                word_hit(cfg_req.addr, port_regs_pkg::OFF_DEV_CAP_TWO): begin
                    state_nxt.rdata = port_regs_pkg::DEV_CAP_TWO_VAL; // RULE10 RULE11
                end
                word_hit(cfg_req.addr, port_regs_pkg::OFF_DEV_CTL_STAT_2): begin
                    state_nxt.rdata[port_regs_pkg::DC2_LTR_EN] = state_r.ltr_enable;
                    state_nxt.rdata[port_regs_pkg::DC2_OBFF_HI:port_regs_pkg::DC2_OBFF_LO] =
                        state_r.obff_mode;
                end
                word_hit(cfg_req.addr, port_regs_pkg::OFF_LINK_CTL_STAT_2): begin
                    state_nxt.rdata = lc2_word;
                end
                word_hit(cfg_req.addr, port_regs_pkg::OFF_ERR_HEADER): begin
                    state_nxt.rdata = {port_regs_pkg::AER_NEXT_PTR, port_regs_pkg::AER_CAP_VER,
                                       port_regs_pkg::AER_CAP_ID}; // RULE15
                end
                word_hit(cfg_req.addr, port_regs_pkg::OFF_UNC_FLAGS): begin
                    state_nxt.rdata = unc_flags;
                end
                word_hit(cfg_req.addr, port_regs_pkg::OFF_UNC_MASKS): begin
                    state_nxt.rdata = state_r.unc_masks;
                end
                default: begin
                    state_nxt.rdata = '0;
                end
            endcase
        end

        // Conventional reset returns only the non-sticky fields.
        if (conventional_reset) begin // RULE26
            state_nxt.slot_ctl      = '0;
            state_nxt.ltr_enable    = 1'b0; // RULE12
            state_nxt.obff_mode     = port_regs_pkg::OBFF_RST; // RULE13
            state_nxt.auto_off      = 1'b0;
            state_nxt.hotplug_event = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r              <= '0;
            state_r.target_speed <= port_regs_pkg::SPEED_RST;
            state_r.unc_masks    <= port_regs_pkg::UNC_RST; // RULE22 RULE26
            state_r.attn_prev    <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg_rdata                            = state_r.rdata;
    assign err_report                           = state_r.err_report;
    assign hotplug_event                        = state_r.hotplug_event;
    assign link_ctl.ltr_enable                  = state_r.ltr_enable;
    assign link_ctl.obff_mode                   = state_r.obff_mode;
    assign link_ctl.autonomous_speed_change_off = state_r.auto_off;
    assign link_ctl.target_link_speed           = state_r.target_speed;
    assign link_ctl.select_deemphasis           = downstream;
endmodule : port_regs
`default_nettype wire

// ==== test/cfg_master.sv ====
// Purpose: Configuration software model that issues single-word register accesses.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes:   Write data is inverted once a write is over, so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module cfg_master (
    input  wire logic              clk,
    input  wire logic [31:0]       cfg_rdata,
    output var port_regs_pkg::cfg_req_t cfg_req
);
    initial cfg_req = '0;
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        cfg_req.addr  <= a;
        cfg_req.wdata <= d;
        cfg_req.wr    <= 1'b1;
        @(posedge clk);
        cfg_req.wr    <= 1'b0;
        cfg_req.wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        cfg_req.addr <= a;
        cfg_req.rd   <= 1'b1;
        @(posedge clk);
        cfg_req.rd <= 1'b0;
        #1 d = cfg_rdata;
    endtask : rd
endmodule : cfg_master
`default_nettype wire

// ==== test/port_regs_sva.sv ====
// Purpose: Port-level checks of the configuration register block.
// Assumes: Only the top module's ports are visible.
// Notes:   up_r counts edges after reset so synchroniser latency is not flagged.
`timescale 1ns/1ps
`default_nettype none
module port_regs_sva (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic                       conventional_reset,
    input wire port_regs_pkg::cfg_req_t    cfg_req,
    input wire logic [31:0]                cfg_rdata,
    input wire port_regs_pkg::slot_pins_t  slot_pins,
    input wire logic [31:0]                err_event,
    input wire logic [31:0]                err_report,
    input wire logic                       hotplug_event,
    input wire port_regs_pkg::link_ctl_t   link_ctl
);
    logic [1:0] up_r;
    logic [9:0] wa;
    assign wa = cfg_req.addr[11:2];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_upstream_dark: assert property (
        $past(cfg_req.rd) && $past(wa) == 10'h036 && up_r == 2'h3 && !slot_pins.downstream
        && !$past(slot_pins.downstream, 3) |-> cfg_rdata == 32'h0) else $error("D8h upstream");
    a_cap_two_val: assert property (
        $past(cfg_req.rd) && $past(wa) == 10'h039 |-> cfg_rdata == 32'h0004_0800)
        else $error("capabilities 2 value wrong");
    a_header_val: assert property (
        $past(cfg_req.rd) && $past(wa) == 10'h040 |-> cfg_rdata == 32'h1401_0001)
        else $error("error reporting header wrong");
    a_report_cause: assert property (
        (err_report & ~($past(err_event) & 32'h003F_F011)) == 32'h0) else $error("stray report");
    a_ctl_write: assert property (
        cfg_req.wr && wa == 10'h03A && !conventional_reset |=> link_ctl.ltr_enable ==
        $past(cfg_req.wdata[10]) && link_ctl.obff_mode == $past(cfg_req.wdata[14:13]))
        else $error("control 2 write lost");
    a_conv_clear: assert property (
        conventional_reset |=> !link_ctl.ltr_enable && link_ctl.obff_mode == 2'h0 && !hotplug_event)
        else $error("non-sticky field kept");
    a_speed_keep: assert property (
        conventional_reset && !(cfg_req.wr && wa == 10'h03C) |=> $stable(link_ctl.target_link_speed))
        else $error("sticky speed lost");
    a_sel_deemp: assert property (
        up_r == 2'h3 |-> link_ctl.select_deemphasis == $past(slot_pins.downstream, 2))
        else $error("de-emphasis select wrong");
    c_report: cover property (err_report != 32'h0);
    c_hotplug: cover property (hotplug_event);
    c_conv: cover property (conventional_reset);
endmodule : port_regs_sva
bind port_regs port_regs_sva port_regs_sva_inst (.clk(clk), .reset_n(reset_n),
    .conventional_reset(conventional_reset), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .slot_pins(slot_pins), .err_event(err_event), .err_report(err_report),
    .hotplug_event(hotplug_event), .link_ctl(link_ctl));
`default_nettype wire

// ==== test/port_regs_bench.sv ====
// Purpose: Self-checking bench for the configuration register block.
// Assumes: Pins settle through two flops plus one edge stage.
// Notes:   Flag and mask expectations are tracked in plain variables.
`timescale 1ns/1ps
`default_nettype none
module port_regs_bench;
    logic clk, reset_n, conventional_reset, hp_cmd_done, dll_active, hotplug_event;
    port_regs_pkg::cfg_req_t   cfg_req;
    port_regs_pkg::slot_pins_t slot_pins;
    port_regs_pkg::link_ctl_t  link_ctl;
    logic [31:0] cfg_rdata, err_event, err_report, e, m, c, flags;
    logic [11:0] ra [11] = '{12'h0E4, 12'h0E8, 12'h0EC, 12'h0F0, 12'h0F4, 12'h0F8, 12'h100,
                             12'h104, 12'h108, 12'h0D8, 12'h200};
    logic [31:0] rv [11] = '{32'h0004_0800, 32'h0, 32'h0, 32'h0001_0042, 32'h0, 32'h0,
                             32'h1401_0001, 32'h0, 32'h0, 32'h0040_0000, 32'h0};
    int errors = 0;
    int n_compared = 0;
    port_regs port_regs_inst(.clk(clk), .reset_n(reset_n), .conventional_reset(conventional_reset),
        .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .slot_pins(slot_pins), .hp_cmd_done(hp_cmd_done),
        .dll_active(dll_active), .err_event(err_event), .err_report(err_report),
        .hotplug_event(hotplug_event), .link_ctl(link_ctl));
    cfg_master cfg_master_inst (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        cfg_master_inst.rd(a, v);
        check("cfg_rdata", exp, v);
    endtask : rd_check
    task automatic err_pulse(input logic [31:0] ev);
        @(posedge clk);
        err_event <= ev;
        @(posedge clk);
        err_event <= 32'h0;
    endtask : err_pulse
    task automatic pins(input logic [5:0] p, input int n);
        slot_pins <= p;
        repeat (n) @(posedge clk);
    endtask : pins
    task automatic finish_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        errors++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        conventional_reset = 1'b0;
        hp_cmd_done = 1'b0;
        dll_active = 1'b0;
        err_event = 32'h0;
        slot_pins = 6'h03;
        flags = 32'h0;
        void'($urandom(78608));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            rd_check(ra[i], rv[i]);
        end
        cfg_master_inst.wr(12'h0D8, 32'h0000_103B);
        hp_cmd_done <= 1'b1;
        dll_active <= 1'b1;
        slot_pins <= 6'h3F;
        @(posedge clk);
        hp_cmd_done <= 1'b0;
        repeat (5) @(posedge clk);
        rd_check(12'h0D8, 32'h013B_103B);
        check("hotplug_event", 32'h1, {31'h0, hotplug_event});
        cfg_master_inst.wr(12'h0D8, 32'h013F_103B);
        rd_check(12'h0D8, 32'h0020_103B);
        check("hotplug_event", 32'h0, {31'h0, hotplug_event});
        cfg_master_inst.wr(12'h0D8, 32'h0000_101B);
        pins(6'h1F, 4);
        pins(6'h3F, 6);
        rd_check(12'h0D8, 32'h0021_101B);
        check("hotplug_event", 32'h0, {31'h0, hotplug_event});
        for (int i = 0; i < 3; i++) begin
            m = $urandom & 32'h003F_F011;
            e = $urandom & 32'h003F_F011;
            c = $urandom;
            cfg_master_inst.wr(12'h108, m);
            err_pulse(e);
            #1 check("err_report", e & ~m, err_report);
            flags = flags | e;
            rd_check(12'h104, flags);
            rd_check(12'h108, m);
            cfg_master_inst.wr(12'h104, c);
            flags = flags & ~c;
            rd_check(12'h104, flags);
        end
        fork
            cfg_master_inst.wr(12'h104, 32'hFFFF_FFFF);
            err_pulse(32'h0000_0001);
        join
        rd_check(12'h104, 32'h0000_0001);
        cfg_master_inst.wr(12'h0E8, 32'h0000_6400);
        cfg_master_inst.wr(12'h0F0, 32'h0000_1FB1);
        #1 check("link_ctl", 32'h0000_01E3, {23'h0, link_ctl});
        rd_check(12'h0F0, 32'h0001_1FF1);
        conventional_reset <= 1'b1;
        @(posedge clk);
        conventional_reset <= 1'b0;
        rd_check(12'h104, 32'h0000_0001);
        rd_check(12'h108, m);
        rd_check(12'h0D8, 32'h0020_0000);
        check("link_ctl", 32'h0000_0003, {23'h0, link_ctl});
        pins(6'h3D, 6);
        rd_check(12'h0D8, 32'h0068_0000);
        pins(6'h3E, 5);
        rd_check(12'h0D8, 32'h0);
        rd_check(12'h0F0, 32'h0000_1F91);
        finish_test();
    end
endmodule : port_regs_bench
`default_nettype wire
